// ===== hw/ioc_pkg.sv
// Purpose: Constants, types and helpers for the internal oscillator control block
// Assumes: AHB-Lite register access, one 100 MHz clock
// Notes: Slow oscillator periods are modelled by tick dividers on hclk
// Functional notes
// - Warm-up code n gives 2^n counter cycles
// - Start-up counter runs on ultra-low-power ticks
// - Two slow cycles of sync before ready
// - Request-driven: run only while peripheral requests
// - Not request-driven: enabled oscillator runs continuously
// - Sleep without keep-running disables the oscillator
// - Sleep with keep-running follows normal run rules
// - Slow output driven only with output enable
// - Slow oscillator follows its enable bit
// - Ultra-low-power freeze blocks its register writes
// - Ultra-low-power trim loaded from flash
// - Reserved bits read zero, software writes zero
// - Fast band select at 31:30, flash loaded
// - Fast trim 27:16, temperature and process parts
// - Fast divider 1,2,4,8; resets to 8
// - Fast enable reads settled state
// - Slow oscillator freeze blocks its writes
package ioc_pkg;
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          SLOW_PERIOD_NS = 30518;
   localparam int          SLOW_DIV       = SLOW_PERIOD_NS / CLK_PERIOD_NS;
   localparam int          FAST_SETTLE_NS = 2000;
   localparam int          FAST_SETTLE    = (FAST_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0]  SYNC_LAST      = 2'h1;
   localparam logic [11:0] ADDR_STATUS    = 12'h00C;
   localparam logic [11:0] ADDR_SLOW      = 12'h018;
   localparam logic [11:0] ADDR_ULP       = 12'h01C;
   localparam logic [11:0] ADDR_FAST      = 12'h020;
   localparam int          EN_BIT         = 1;
   localparam int          OUT32K_BIT     = 2;
   localparam int          STBY_BIT       = 6;
   localparam int          ONDEM_BIT      = 7;
   localparam int          SU_LSB         = 8;
   localparam int          SLOW_LOCK_BIT  = 12;
   localparam int          TRIM_LSB       = 16;
   localparam int          ULP_LOCK_BIT   = 7;
   localparam int          DIV_LSB        = 8;
   localparam int          BAND_LSB       = 30;
   localparam int          READY_BIT      = 0;
   localparam logic [31:0] SLOW_RST       = 32'h00000080;
   localparam logic [31:0] SLOW_WMASK     = 32'h007F17C6;
   localparam logic [7:0]  ULP_WMASK      = 8'h9F;
   localparam logic [31:0] FAST_RST       = 32'h00000382;
   localparam logic [31:0] FAST_WMASK     = 32'hCFFF03C2;
   localparam logic [31:0] FAST_CAL_MASK  = 32'hCFFF0000;

   typedef enum logic [1:0] {
      FAST_OFF      = 2'b00,
      FAST_STARTING = 2'b01,
      FAST_ON       = 2'b10,
      FAST_STOPPING = 2'b11
   } ioc_fast_t;

   typedef enum logic [1:0] {
      SU_IDLE  = 2'b00,
      SU_COUNT = 2'b01,
      SU_SYNC  = 2'b10,
      SU_READY = 2'b11
   } ioc_su_t;

   // Effective run condition for the slow and fast oscillators
   function automatic logic ioc_runs(input logic en, input logic ondem, input logic keep,
                                     input logic req, input logic stby);
      ioc_runs = en && (!ondem || req) && (!stby || keep);
   endfunction
endpackage

// ===== hw/ioc_startup.sv
// Purpose: Start-up counter and ready synchroniser of the slow internal oscillator
// Assumes: Ticks are one-cycle enables on hclk
// Notes: Ready drops on the clock edge after run falls
`timescale 1ns/1ps
`default_nettype none
module ioc_startup
   import ioc_pkg::*;
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       run,
   input  wire logic [2:0] sel,
   input  wire logic       ulp_tick,
   input  wire logic       osc_tick,
   output logic            ready
);
   ioc_su_t    state_reg;
   logic [6:0] cnt_reg;
   logic [1:0] sync_reg;
   logic [6:0] lim;

   assign lim = 7'((8'h01 << sel) - 8'h01);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= SU_IDLE;
         cnt_reg   <= 7'h00;
         sync_reg  <= 2'h0;
      end else if (!run) begin
         state_reg <= SU_IDLE;
      end else begin
         unique case (state_reg)
            SU_IDLE: begin
               state_reg <= SU_COUNT;
               cnt_reg   <= 7'h00;
            end
            SU_COUNT: begin
               if (ulp_tick) begin
                  if (cnt_reg == lim) begin
                     state_reg <= SU_SYNC;
                     sync_reg  <= 2'h0;
                  end else begin
                     cnt_reg <= cnt_reg + 7'h01;
                  end
               end
            end
            SU_SYNC: begin
               if (osc_tick) begin
                  if (sync_reg == SYNC_LAST) begin
                     state_reg <= SU_READY;
                  end else begin
                     sync_reg <= sync_reg + 2'h1;
                  end
               end
            end
            SU_READY: begin
               state_reg <= SU_READY;
            end
         endcase
      end
   end

   assign ready = (state_reg == SU_READY);

   chk_count_length: assert property (@(posedge hclk) disable iff (!hresetn)
      (run && state_reg == SU_COUNT && ulp_tick && cnt_reg == lim) |=> state_reg == SU_SYNC)
      else $error("start-up count did not end at its limit");
   chk_sync_delay: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(ready) |-> $past(state_reg == SU_SYNC && osc_tick && sync_reg == SYNC_LAST))
      else $error("ready rose without full sync delay");
   chk_ready_drop: assert property (@(posedge hclk) disable iff (!hresetn)
      !run |=> !ready)
      else $error("ready stayed while stopped");
endmodule
`default_nettype wire

// ===== hw/ioc_ctrl.sv
// Purpose: Register bank of three internal oscillators, run control of the slow and fast ones
// Assumes: Requests, standby and calibration inputs come from hclk logic
// Notes: Zero-wait AHB-Lite slave, always OKAY
`timescale 1ns/1ps
`default_nettype none
module ioc_ctrl
   import ioc_pkg::*;
#(
   parameter int ULP_DIV   = SLOW_DIV,
   parameter int OSC_DIV   = SLOW_DIV,
   parameter int SETTLE    = FAST_SETTLE
)(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        standby,
   input  wire logic        slow_req,
   input  wire logic        fast_req,
   input  wire logic [4:0]  ulp_trim_flash,
   input  wire logic [11:0] fast_trim_flash,
   input  wire logic [1:0]  fast_band_flash,
   output logic             slow_osc_run_o,
   output logic             slow_clk_out_o,
   output logic [6:0]       slow_trim_o,
   output logic [4:0]       ulp_trim_o,
   output logic             fast_osc_run_o,
   output logic             fast_clk_en_o,
   output logic [1:0]       fast_div_sel_o,
   output logic [5:0]       fast_temp_trim_o,
   output logic [5:0]       fast_proc_trim_o,
   output logic [1:0]       fast_band_o
);
   logic [31:0] slow_ctrl_reg;
   logic [7:0]  ulp_ctrl_reg;
   logic [31:0] fast_ctrl_reg;
   logic        cal_done_reg;
   logic        wr_pend_reg;
   logic [11:0] wr_addr_reg;
   logic [11:0] ulp_cnt_reg;
   logic [11:0] osc_cnt_reg;
   logic        ulp_tick_reg;
   logic        osc_tick_reg;
   logic [7:0]  settle_reg;
   logic [2:0]  div_cnt_reg;
   ioc_fast_t   fast_state_reg;
   logic        slow_run_reg;
   logic        fast_run_reg;
   logic        slow_out_reg;
   logic        fast_tick_reg;
   logic [31:0] rdata_reg;
   logic        slow_ready;
   logic        addr_ok;
   logic        slow_next;
   logic        fast_next;
   logic        fast_rb;
   logic [31:0] rdata_next;
   logic [2:0]  div_lim;

   // Bus address phase
   assign addr_ok = hsel && htrans[1] && hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 12'h000;
      end else begin
         wr_pend_reg <= addr_ok && hwrite;
         if (addr_ok) begin
            wr_addr_reg <= haddr[11:0];
         end
      end
   end

   // Flash calibration is caught once after reset release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cal_done_reg <= 1'b0;
      end else begin
         cal_done_reg <= 1'b1;
      end
   end

   // Slow internal oscillator control
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slow_ctrl_reg <= SLOW_RST;
      end else if (wr_pend_reg && wr_addr_reg == ADDR_SLOW
                   && !slow_ctrl_reg[SLOW_LOCK_BIT]) begin
         slow_ctrl_reg <= hwdata & SLOW_WMASK;
      end
   end

   // Ultra-low-power oscillator control
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ulp_ctrl_reg <= 8'h00;
      end else if (!cal_done_reg) begin
         ulp_ctrl_reg <= {3'h0, ulp_trim_flash};
      end else if (wr_pend_reg && wr_addr_reg == ADDR_ULP
                   && !ulp_ctrl_reg[ULP_LOCK_BIT]) begin
         ulp_ctrl_reg <= hwdata[7:0] & ULP_WMASK;
      end
   end

   // Fast oscillator control
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fast_ctrl_reg <= FAST_RST;
      end else if (!cal_done_reg) begin
         fast_ctrl_reg <= (fast_ctrl_reg & ~FAST_CAL_MASK)
                          | {fast_band_flash, 2'h0, fast_trim_flash, 16'h0000};
      end else if (wr_pend_reg && wr_addr_reg == ADDR_FAST) begin
         fast_ctrl_reg <= hwdata & FAST_WMASK;
      end
   end

   // Ultra-low-power tick, free running
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ulp_cnt_reg  <= 12'h000;
         ulp_tick_reg <= 1'b0;
      end else if (ulp_cnt_reg == 12'(ULP_DIV - 1)) begin
         ulp_cnt_reg  <= 12'h000;
         ulp_tick_reg <= 1'b1;
      end else begin
         ulp_cnt_reg  <= ulp_cnt_reg + 12'h001;
         ulp_tick_reg <= 1'b0;
      end
   end

   // Slow oscillator tick, only while it runs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         osc_cnt_reg  <= 12'h000;
         osc_tick_reg <= 1'b0;
      end else if (!slow_run_reg) begin
         osc_cnt_reg  <= 12'h000;
         osc_tick_reg <= 1'b0;
      end else if (osc_cnt_reg == 12'(OSC_DIV - 1)) begin
         osc_cnt_reg  <= 12'h000;
         osc_tick_reg <= 1'b1;
      end else begin
         osc_cnt_reg  <= osc_cnt_reg + 12'h001;
         osc_tick_reg <= 1'b0;
      end
   end

   // Run decisions
   assign slow_next = ioc_runs(slow_ctrl_reg[EN_BIT], slow_ctrl_reg[ONDEM_BIT],
                               slow_ctrl_reg[STBY_BIT], slow_req, standby);
   assign fast_next = ioc_runs(fast_state_reg == FAST_ON, fast_ctrl_reg[ONDEM_BIT],
                               fast_ctrl_reg[STBY_BIT], fast_req, standby);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slow_run_reg <= 1'b0;
         fast_run_reg <= 1'b0;
         slow_out_reg <= 1'b0;
      end else begin
         slow_run_reg <= slow_next;
         fast_run_reg <= fast_next;
         slow_out_reg <= slow_next && slow_ready && slow_ctrl_reg[OUT32K_BIT];
      end
   end

   ioc_startup u_startup (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .run      (slow_run_reg),
      .sel      (slow_ctrl_reg[SU_LSB +: 3]),
      .ulp_tick (ulp_tick_reg),
      .osc_tick (osc_tick_reg),
      .ready    (slow_ready)
   );

   // Fast oscillator enable sequencing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fast_state_reg <= FAST_OFF;
         settle_reg     <= 8'h00;
      end else begin
         unique case (fast_state_reg)
            FAST_OFF: begin
               if (fast_ctrl_reg[EN_BIT]) begin
                  fast_state_reg <= FAST_STARTING;
                  settle_reg     <= 8'h00;
               end
            end
            FAST_STARTING: begin
               if (settle_reg == 8'(SETTLE - 1)) begin
                  fast_state_reg <= FAST_ON;
               end else begin
                  settle_reg <= settle_reg + 8'h01;
               end
            end
            FAST_ON: begin
               if (!fast_ctrl_reg[EN_BIT]) begin
                  fast_state_reg <= FAST_STOPPING;
                  settle_reg     <= 8'h00;
               end
            end
            FAST_STOPPING: begin
               if (settle_reg == 8'(SETTLE - 1)) begin
                  fast_state_reg <= FAST_OFF;
               end else begin
                  settle_reg <= settle_reg + 8'h01;
               end
            end
         endcase
      end
   end

   assign fast_rb = fast_state_reg[1];

   // Prescaled fast clock enable
   assign div_lim = 3'((4'h1 << fast_ctrl_reg[DIV_LSB +: 2]) - 4'h1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt_reg   <= 3'h0;
         fast_tick_reg <= 1'b0;
      end else if (!fast_run_reg) begin
         div_cnt_reg   <= 3'h0;
         fast_tick_reg <= 1'b0;
      end else if (div_cnt_reg >= div_lim) begin
         div_cnt_reg   <= 3'h0;
         fast_tick_reg <= 1'b1;
      end else begin
         div_cnt_reg   <= div_cnt_reg + 3'h1;
         fast_tick_reg <= 1'b0;
      end
   end

   // Read data, registered for the data phase
   always_comb begin
      rdata_next = 32'h00000000;
      unique case (haddr[11:0])
         ADDR_STATUS: rdata_next[READY_BIT] = slow_ready;
         ADDR_SLOW:   rdata_next = slow_ctrl_reg;
         ADDR_ULP:    rdata_next = {24'h000000, ulp_ctrl_reg};
         ADDR_FAST:   rdata_next = {fast_ctrl_reg[31:2], fast_rb, 1'b0};
         default:     rdata_next = 32'h00000000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_reg <= 32'h00000000;
      end else if (addr_ok && !hwrite) begin
         rdata_reg <= rdata_next;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   assign hrdata           = rdata_reg;
   assign slow_osc_run_o   = slow_run_reg;
   assign slow_clk_out_o   = slow_out_reg;
   assign slow_trim_o      = slow_ctrl_reg[TRIM_LSB +: 7];
   assign ulp_trim_o       = ulp_ctrl_reg[4:0];
   assign fast_osc_run_o   = fast_run_reg;
   assign fast_clk_en_o    = fast_tick_reg;
   assign fast_div_sel_o   = fast_ctrl_reg[DIV_LSB +: 2];
   assign fast_temp_trim_o = fast_ctrl_reg[TRIM_LSB + 6 +: 6];
   assign fast_proc_trim_o = fast_ctrl_reg[TRIM_LSB +: 6];
   assign fast_band_o      = fast_ctrl_reg[BAND_LSB +: 2];

   chk_request_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      (slow_ctrl_reg[ONDEM_BIT] && !slow_req) |=> !slow_osc_run_o)
      else $error("slow oscillator ran without request");
   chk_always_on: assert property (@(posedge hclk) disable iff (!hresetn)
      (slow_ctrl_reg[EN_BIT] && !slow_ctrl_reg[ONDEM_BIT] && !standby) |=> slow_osc_run_o)
      else $error("enabled slow oscillator not running");
   chk_standby_off: assert property (@(posedge hclk) disable iff (!hresetn)
      (standby && !fast_ctrl_reg[STBY_BIT]) |=> !fast_osc_run_o)
      else $error("fast oscillator ran in standby");
   chk_out_enable: assert property (@(posedge hclk) disable iff (!hresetn)
      slow_clk_out_o |-> $past(slow_ctrl_reg[OUT32K_BIT] && slow_ready))
      else $error("slow output without enable");
   chk_ulp_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
      (cal_done_reg && $past(ulp_ctrl_reg[ULP_LOCK_BIT])) |-> $stable(ulp_ctrl_reg))
      else $error("frozen register changed");
   chk_fast_settle: assert property (@(posedge hclk) disable iff (!hresetn)
      (fast_state_reg == FAST_OFF && fast_ctrl_reg[EN_BIT]) |=> !fast_rb [*2])
      else $error("fast enable read back too early");
endmodule
`default_nettype wire

// ===== verification/ioc_periph_model.sv
// Purpose: Peripheral clock requesters and flash calibration store
// Assumes: Requests are registered on hclk like real requesters
// Notes: Calibration values are arbitrary test patterns
`timescale 1ns/1ps
`default_nettype none
module ioc_periph_model #(
   parameter logic [4:0]  ULP_CAL  = 5'h15,
   parameter logic [11:0] FAST_CAL = 12'hA5C,
   parameter logic [1:0]  BAND_CAL = 2'h2
)(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        want_slow,
   input  wire logic        want_fast,
   output logic             slow_req,
   output logic             fast_req,
   output logic [4:0]       ulp_trim_flash,
   output logic [11:0]      fast_trim_flash,
   output logic [1:0]       fast_band_flash
);
   // Requests change only just after a clock edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slow_req <= 1'b0;
         fast_req <= 1'b0;
      end else begin
         slow_req <= want_slow;
         fast_req <= want_fast;
      end
   end
   // Factory calibration words held steady
   assign ulp_trim_flash  = ULP_CAL;
   assign fast_trim_flash = FAST_CAL;
   assign fast_band_flash = BAND_CAL;
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Purpose: Self-checking bench of the oscillator control block
// Assumes: AHB-Lite master tasks, shortened tick dividers
// Notes: Oscillator outputs are sampled on the falling edge, bus read data on the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import ioc_pkg::*;
;
   localparam int          DIV  = 4;
   localparam logic [4:0]  UCAL = 5'h15;
   localparam logic [11:0] FCAL = 12'hA5C;
   localparam logic [1:0]  BAND = 2'h2;
   logic        hclk, hresetn, hsel, hwrite, standby, want_slow, want_fast;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, div_sel, band;
   logic [2:0]  hsize;
   logic        hready, hresp, slow_req, fast_req, s_run, s_out, f_run, f_en;
   logic [4:0]  ulp_fl, ulp_trim;
   logic [11:0] fast_fl;
   logic [1:0]  band_fl;
   logic [6:0]  slow_trim;
   logic [5:0]  temp_trim, proc_trim;
   int          err_total, check_count;

   ioc_periph_model #(.ULP_CAL(UCAL), .FAST_CAL(FCAL), .BAND_CAL(BAND)) u_model (
      .hclk(hclk), .hresetn(hresetn), .want_slow(want_slow), .want_fast(want_fast),
      .slow_req(slow_req), .fast_req(fast_req), .ulp_trim_flash(ulp_fl),
      .fast_trim_flash(fast_fl), .fast_band_flash(band_fl));

   ioc_ctrl #(.ULP_DIV(DIV), .OSC_DIV(DIV), .SETTLE(3)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .standby(standby),
      .slow_req(slow_req), .fast_req(fast_req), .ulp_trim_flash(ulp_fl),
      .fast_trim_flash(fast_fl), .fast_band_flash(band_fl), .slow_osc_run_o(s_run),
      .slow_clk_out_o(s_out), .slow_trim_o(slow_trim), .ulp_trim_o(ulp_trim),
      .fast_osc_run_o(f_run), .fast_clk_en_o(f_en), .fast_div_sel_o(div_sel),
      .fast_temp_trim_o(temp_trim), .fast_proc_trim_o(proc_trim), .fast_band_o(band));

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic do_reset;
      hresetn <= 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
   endtask

   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, a};
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask

   task automatic neg(input int n);
      repeat (n) @(negedge hclk);
   endtask

   task automatic t_reset;
      logic [31:0] q;
      neg(8);
      chk("div_rst", 32'(div_sel), 32'h3);
      chk("ulp_trim", 32'(ulp_trim), 32'(UCAL));
      chk("band", 32'(band), 32'(BAND));
      chk("temp_trim", 32'(temp_trim), 32'(FCAL[11:6]));
      chk("proc_trim", 32'(proc_trim), 32'(FCAL[5:0]));
      rd(ADDR_SLOW, q);
      chk("slow_rst", q, 32'h00000080);
      rd(ADDR_ULP, q);
      chk("ulp_rst", q, 32'(UCAL));
      rd(ADDR_FAST, q);
      chk("fast_rst", q, {BAND, 2'h0, FCAL, 16'h0382});
      rd(ADDR_STATUS, q);
      chk("status", q, 32'h0);
      rd(12'h040, q);
      chk("unmapped", q, 32'h0);
      chk("hresp", 32'(hresp), 32'h0);
      want_fast <= 1'b1;
      neg(1);
      chk("hreadyout", 32'(hready), 32'h1);
      chk("fast_no_req", 32'(f_run), 32'h0);
      neg(3);
      chk("fast_req_on", 32'(f_run), 32'h1);
      @(posedge hclk);
      want_fast <= 1'b0;
      neg(4);
      chk("fast_req_off", 32'(f_run), 32'h0);
   endtask

   task automatic t_fast_div;
      int n;
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_FAST, {BAND, 2'h0, FCAL, 6'h0, c[1:0], 8'h02});
         neg(4);
         n = 0;
         chk("fast_run", 32'(f_run), 32'h1);
         for (int k = 0; k < 16; k++) begin
            neg(1);
            if (f_en === 1'b1) n++;
         end
         chk("pulses", 32'(n), 32'(16 >> c));
         chk("div_sel", 32'(div_sel), 32'(c));
      end
   endtask

   task automatic t_fast_en;
      logic [31:0] q;
      int          k;
      for (int e = 0; e < 2; e++) begin
         wr(ADDR_FAST, {BAND, 2'h0, FCAL, 14'h00C0, e[0], 1'b0});
         rd(ADDR_FAST, q);
         chk("fast_transit", 32'(q[1]), 32'(!e[0]));
         k = 0;
         do begin
            rd(ADDR_FAST, q);
            k++;
         end while (q[1] !== e[0] && k < 20);
         chk("fast_settled", 32'(q[1]), 32'(e[0]));
      end
   endtask

   task automatic t_run_matrix;
      logic en, od, kp, rq, sb, exp;
      for (int i = 0; i < 32; i++) begin
         {en, od, kp, rq, sb} = i[4:0];
         @(posedge hclk);
         standby <= sb;
         want_slow <= rq;
         wr(ADDR_SLOW, {9'h0, 7'h2A, 8'h0, od, kp, 4'h0, en, 1'b0});
         neg(3);
         exp = en && (!od || rq) && (!sb || kp);
         chk("slow_run", 32'(s_run), 32'(exp));
      end
      chk("slow_trim", 32'(slow_trim), 32'h2A);
      @(posedge hclk);
      standby <= 1'b0;
      want_slow <= 1'b0;
   endtask

   task automatic t_startup;
      logic [31:0] q;
      int          k, n, lo, hi;
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_SLOW, 32'h0);
         neg(3);
         rd(ADDR_STATUS, q);
         chk("rdy_clear", q, 32'h0);
         wr(ADDR_SLOW, {21'h0, c[2:0], 8'h06});
         k = 0;
         while (s_run !== 1'b1 && k < 20) begin
            neg(1);
            k++;
         end
         n = 0;
         while (s_out !== 1'b1 && n < 2000) begin
            neg(1);
            n++;
         end
         lo = ((1 << c) - 1) * DIV + 2;
         hi = ((1 << c) + 3) * DIV + 4;
         chk("startup_len", 32'(n >= lo && n <= hi), 32'h1);
         rd(ADDR_STATUS, q);
         chk("rdy_set", q, 32'h1);
      end
      wr(ADDR_SLOW, 32'h2);
      neg(3);
      chk("out_off", 32'(s_out), 32'h0);
   endtask

   task automatic t_freeze;
      logic [31:0] q;
      wr(ADDR_ULP, 32'hFF);
      rd(ADDR_ULP, q);
      chk("ulp_lock", q, 32'h9F);
      wr(ADDR_ULP, 32'h0);
      rd(ADDR_ULP, q);
      chk("ulp_frozen", q, 32'h9F);
      chk("ulp_trim_o", 32'(ulp_trim), 32'h1F);
      wr(ADDR_SLOW, 32'hFFFFFFFF);
      rd(ADDR_SLOW, q);
      chk("slow_lock", q, 32'h007F17C6);
      wr(ADDR_SLOW, 32'h0);
      rd(ADDR_SLOW, q);
      chk("slow_frozen", q, 32'h007F17C6);
      do_reset();
      rd(ADDR_SLOW, q);
      chk("slow_unlock", q, 32'h00000080);
   endtask

   initial begin
      #200000;
      err_total++;
      tally_and_finish();
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      standby = 1'b0;
      want_slow = 1'b0;
      want_fast = 1'b0;
      err_total = 0;
      check_count = 0;
      do_reset();
      t_reset();
      t_fast_div();
      t_fast_en();
      t_run_matrix();
      t_startup();
      t_freeze();
      tally_and_finish();
   end
endmodule
`default_nettype wire
